// file: acs_pkg.sv
// Constants shared by the converter sequencer files
package acs_pkg;
   // Register bus shape, field and counter widths
   localparam int ADDR_W = 3;
   localparam int DATA_W = 16;
   localparam int RES_W = 10;
   localparam int SEL_W = 3;
   localparam int PRE_W = 7;
   localparam int CYC_W = 5;
   localparam int EVT_W = 2;

   // Register addresses
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 3'h0;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h1;
   localparam logic [ADDR_W-1:0] ADDR_CLEAR = 3'h2;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_EN = 3'h3;
   localparam logic [ADDR_W-1:0] ADDR_DATA = 3'h4;

   // Control register fields
   localparam int CTL_ENABLE = 0;
   localparam int CTL_START = 1;
   localparam int CTL_AUTO = 2;
   localparam int CTL_FREE = 3;
   localparam int CTL_SEL_LO = 4;

   // Event bits of status, clear and enable registers
   localparam int EVT_DONE = 0;
   localparam int EVT_MISSED = 1;

   // Conversion timing in converter clock cycles
   localparam logic [CYC_W-1:0] NORM_CYCLES = 5'h0d;
   localparam logic [CYC_W-1:0] FIRST_CYCLES = 5'h19;
   localparam logic [CYC_W-1:0] SH_NORM_CYC = 5'h01;
   localparam logic [CYC_W-1:0] SH_FIRST_CYC = 5'h0d;
   localparam logic [CYC_W-1:0] SH_AUTO_CYC = 5'h01;

   typedef enum logic [0:0] {
      ST_IDLE,
      ST_CONV
   } acs_state_t;
endpackage

// file: acs_pin_sync.sv
// Two-stage pin synchroniser with a registered rising-edge pulse on bit 0
`timescale 1ns/1ps
`default_nettype none
module acs_pin_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Pin side
   input wire logic [W-1:0] pin_in,
   // Synchronised side
   output logic [W-1:0] level_out,
   output logic rise_out
);
   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;
   logic prev_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= pin_in;
         sync_r <= meta_r;
      end
   end

   // Edge pulse is the third stage, so pin to pulse is three cycles
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_r <= 1'b0;
         rise_out <= 1'b0;
      end else begin
         prev_r <= sync_r[0];
         rise_out <= sync_r[0] & ~prev_r;
      end
   end

   assign level_out = sync_r;
endmodule // acs_pin_sync
`default_nettype wire

// file: acs_prescaler.sv
// Converter clock prescaler producing rising and falling edge ticks
`timescale 1ns/1ps
`default_nettype none
module acs_prescaler
   import acs_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire logic run,
   input wire logic restart,
   input wire logic [SEL_W-1:0] sel,
   // Ticks
   output logic rise_tick,
   output logic fall_tick
);
   logic [PRE_W-1:0] cnt_r;
   logic [PRE_W-1:0] last;
   logic [PRE_W-1:0] half;

   // Division by 2 << sel; values above 6 fold onto the slowest rate
   always_comb begin
      last = (sel > 3'h6) ? 7'h7f : PRE_W'((8'h02 << sel) - 8'h01);
      half = last >> 1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
      end else if (!run || restart) begin
         cnt_r <= '0;
      end else if (cnt_r >= last) begin
         // Wrap from above too, so a smaller select never waits a full 7-bit lap
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + 7'h01;
      end
   end

   assign rise_tick = run && !restart && (cnt_r == last);
   assign fall_tick = run && !restart && (cnt_r == half);
endmodule // acs_prescaler
`default_nettype wire

// file: acs_sequencer.sv
// Conversion sequencer with register port, interrupt and result capture
`timescale 1ns/1ps
`default_nettype none
// Function
// - Prescaler runs while converter_enable is set, held reset while low.
// - Setting start_conversion starts a conversion at the next converter clock rise.
// - A normal conversion lasts 13 converter clock cycles.
// - First conversion after enabling lasts 25 converter clock cycles.
// - Sample-and-hold at 1.5 cycles normally, 13.5 cycles on first conversion.
// - On completion store result and set conversion_done_flag.
// - Single mode clears start_conversion in the completion cycle.
// - Setting start again begins a new conversion at the next converter clock rise.
// - An auto-trigger event resets the prescaler for a fixed start delay.
// - Auto-trigger without free run: sample-and-hold two converter cycles after the trigger edge, except on first conversion.
// - Trigger path adds three system clock cycles of synchronisation.
// - Free running with auto-trigger off restarts right after completion, start bit stays set.
module acs_sequencer
   import acs_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   // Trigger source and converter pins
   input wire logic trigger_in,
   input wire logic [RES_W-1:0] result_in,
   output logic sample_hold,
   output logic conv_active,
   // Interrupt
   output logic irq
);
   logic rst_meta_r;
   logic rst_n;

   logic converter_enable_r;
   logic start_conversion_r;
   logic auto_trig_r;
   logic free_run_r;
   logic [SEL_W-1:0] presc_sel_r;
   logic [EVT_W-1:0] status_r;
   logic [EVT_W-1:0] irq_en_r;
   logic [RES_W-1:0] sample_r;
   logic [RES_W-1:0] data_r;
   logic first_r;
   logic sample_hold_r;
   logic [DATA_W-1:0] rdata_r;

   acs_state_t state_r;
   logic [CYC_W-1:0] cyc_r;

   logic rise_tick;
   logic fall_tick;
   logic trig_rise;
   logic [RES_W-1:0] result_sync;

   logic wr_ctrl;
   logic wr_clear;
   logic wr_irq_en;
   logic sw_start;
   logic trig_take;
   logic start_now;
   logic done_now;
   logic sh_now;
   logic [CYC_W-1:0] last_cyc;
   logic [EVT_W-1:0] evt_set;
   logic [EVT_W-1:0] evt_clr;

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n <= rst_meta_r;
      end
   end

   // Trigger pin: two sync stages plus edge stage
   acs_pin_sync #(
      .W(1)
   ) u_trig_sync (
      .clk(ref_clk),
      .rst_n(rst_n),
      .pin_in(trigger_in),
      .level_out(),
      .rise_out(trig_rise)
   );

   // Converter result pins come from the analog side, another timing domain
   acs_pin_sync #(
      .W(RES_W)
   ) u_res_sync (
      .clk(ref_clk),
      .rst_n(rst_n),
      .pin_in(result_in),
      .level_out(result_sync),
      .rise_out()
   );

   acs_prescaler u_presc (
      .clk(ref_clk),
      .rst_n(rst_n),
      .run(converter_enable_r),
      .restart(trig_take),
      .sel(presc_sel_r),
      .rise_tick(rise_tick),
      .fall_tick(fall_tick)
   );

   // Address decode of writes
   always_comb begin
      wr_ctrl = 1'b0;
      wr_clear = 1'b0;
      wr_irq_en = 1'b0;
      if (reg_wr && reg_addr == ADDR_CTRL) begin
         wr_ctrl = 1'b1;
      end else if (reg_wr && reg_addr == ADDR_CLEAR) begin
         wr_clear = 1'b1;
      end else if (reg_wr && reg_addr == ADDR_IRQ_EN) begin
         wr_irq_en = 1'b1;
      end
   end

   assign sw_start = wr_ctrl && reg_wdata[CTL_START] && reg_wdata[CTL_ENABLE];

   // Trigger is taken only when idle; a busy converter counts it as missed
   assign trig_take = trig_rise && converter_enable_r && auto_trig_r
      && (state_r == ST_IDLE);

   assign start_now = (state_r == ST_IDLE) && converter_enable_r
      && ((rise_tick && start_conversion_r) || trig_take);

   assign last_cyc = first_r ? FIRST_CYCLES - 5'h01 : NORM_CYCLES - 5'h01;

   assign done_now = (state_r == ST_CONV) && rise_tick
      && (cyc_r == last_cyc);

   // Sample point: half cycle on falling tick, auto mode without free run on a rising tick except in the first conversion
   always_comb begin
      sh_now = 1'b0;
      if (state_r == ST_CONV) begin
         if (first_r) begin
            sh_now = fall_tick && (cyc_r == SH_FIRST_CYC);
         end else if (auto_trig_r && !free_run_r) begin
            sh_now = rise_tick && (cyc_r == SH_AUTO_CYC);
         end else begin
            sh_now = fall_tick && (cyc_r == SH_NORM_CYC);
         end
      end
   end

   // Control register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         converter_enable_r <= 1'b0;
         auto_trig_r <= 1'b0;
         free_run_r <= 1'b0;
         presc_sel_r <= '0;
      end else if (wr_ctrl) begin
         converter_enable_r <= reg_wdata[CTL_ENABLE];
         auto_trig_r <= reg_wdata[CTL_AUTO];
         free_run_r <= reg_wdata[CTL_FREE];
         presc_sel_r <= reg_wdata[CTL_SEL_LO +: SEL_W];
      end
   end

   // Start bit: software sets, hardware clears; writing zero has no effect
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         start_conversion_r <= 1'b0;
      end else if (!converter_enable_r && !sw_start) begin
         start_conversion_r <= 1'b0;
      end else if (sw_start) begin
         start_conversion_r <= 1'b1;
      end else if (trig_take) begin
         start_conversion_r <= 1'b1;
      end else if (done_now && !(free_run_r && !auto_trig_r)) begin
         start_conversion_r <= 1'b0;
      end
   end

   // First-conversion marker armed while disabled
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         first_r <= 1'b1;
      end else if (!converter_enable_r) begin
         first_r <= 1'b1;
      end else if (done_now) begin
         first_r <= 1'b0;
      end
   end

   // Sequencer state and converter cycle count
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         cyc_r <= '0;
      end else if (!converter_enable_r) begin
         state_r <= ST_IDLE;
         cyc_r <= '0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (start_now) begin
                  state_r <= ST_CONV;
                  cyc_r <= '0;
               end
            end
            ST_CONV: begin
               if (done_now && free_run_r && !auto_trig_r) begin
                  cyc_r <= '0;
               end else if (done_now) begin
                  state_r <= ST_IDLE;
                  cyc_r <= '0;
               end else if (rise_tick) begin
                  cyc_r <= cyc_r + 5'h01;
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // Held sample, then result register at completion
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sample_r <= '0;
         data_r <= '0;
         sample_hold_r <= 1'b0;
      end else begin
         sample_hold_r <= sh_now;
         if (sh_now) begin
            sample_r <= result_sync;
         end
         if (done_now) begin
            data_r <= sample_r;
         end
      end
   end

   // Sticky events; a set in the clearing cycle wins
   assign evt_set = {trig_rise && auto_trig_r && converter_enable_r
      && (state_r == ST_CONV), done_now};
   assign evt_clr = wr_clear ? reg_wdata[EVT_W-1:0] : '0;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_r <= '0;
      end else begin
         status_r <= (status_r & ~evt_clr) | evt_set;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_en_r <= '0;
      end else if (wr_irq_en) begin
         irq_en_r <= reg_wdata[EVT_W-1:0];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_r & irq_en_r);
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= '0;
      end else if (!reg_rd) begin
         rdata_r <= '0;
      end else if (reg_addr == ADDR_CTRL) begin
         rdata_r <= '0;
         rdata_r[CTL_ENABLE] <= converter_enable_r;
         rdata_r[CTL_START] <= start_conversion_r || (state_r == ST_CONV);
         rdata_r[CTL_AUTO] <= auto_trig_r;
         rdata_r[CTL_FREE] <= free_run_r;
         rdata_r[CTL_SEL_LO +: SEL_W] <= presc_sel_r;
      end else if (reg_addr == ADDR_STATUS) begin
         rdata_r <= {{(DATA_W-EVT_W){1'b0}}, status_r};
      end else if (reg_addr == ADDR_IRQ_EN) begin
         rdata_r <= {{(DATA_W-EVT_W){1'b0}}, irq_en_r};
      end else if (reg_addr == ADDR_DATA) begin
         rdata_r <= {{(DATA_W-RES_W){1'b0}}, data_r};
      end else begin
         rdata_r <= '0;
      end
   end

   assign reg_rdata = rdata_r;
   assign sample_hold = sample_hold_r;
   assign conv_active = (state_r == ST_CONV);
endmodule // acs_sequencer
`default_nettype wire

// file: acs_sequencer_checker.sv
// Port assertions for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_checker
   import acs_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   // Converter side
   input wire logic sample_hold,
   input wire logic conv_active,
   input wire logic irq
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == '0)
      else $error("read data not zero between reads");
   a_irq_masked: assert property (reg_wr && reg_addr == ADDR_IRQ_EN && reg_wdata[1:0] == 2'h0
      |-> ##2 !irq) else $error("interrupt high while masked");
   a_hold_in_conv: assert property (sample_hold |-> conv_active)
      else $error("sample pulse outside a conversion");
   a_hold_pulse: assert property (sample_hold |=> !sample_hold)
      else $error("sample pulse too long");
   a_unmapped_zero: assert property (reg_rd && reg_addr > ADDR_DATA |=> reg_rdata == '0)
      else $error("unmapped read not zero");
   a_status_width: assert property (reg_rd && reg_addr == ADDR_STATUS |=>
      reg_rdata[DATA_W-1:EVT_W] == '0) else $error("status upper bits set");
   a_result_width: assert property (reg_rd && reg_addr == ADDR_DATA |=>
      reg_rdata[DATA_W-1:RES_W] == '0) else $error("result upper bits set");
   a_start_busy: assert property (reg_rd && reg_addr == ADDR_CTRL && conv_active
      |=> reg_rdata[CTL_START] && reg_rdata[CTL_ENABLE]) else $error("start bit low while busy");
   a_conv_min: assert property ($rose(conv_active) |-> conv_active[*8])
      else $error("conversion too short");
   c_done: cover property ($fell(conv_active));
   c_hold: cover property (sample_hold);
   c_irq: cover property ($rose(irq));
endmodule // acs_sequencer_checker
`default_nettype wire

// file: acs_sequencer_bench.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_bench;
   import acs_pkg::*;
   logic ref_clk, resetn, reg_wr, reg_rd, trigger_in, sample_hold, conv_active, irq;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata, rv;
   logic [RES_W-1:0] result_in;
   int fails, comparisons, len, sh, len2, sh2;
   int cycles = 0;
   acs_sequencer i_acs_sequencer (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .trigger_in(trigger_in), .result_in(result_in), .sample_hold(sample_hold),
      .conv_active(conv_active), .irq(irq));
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   task automatic summarize();
      if (fails == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fails++;
         summarize();
      end
   end
   task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
   endtask
   // Bounded wait for the end of the running conversion
   task automatic wait_idle();
      for (int w = 0; w < 300 && conv_active !== 1'b0; w++) @(posedge ref_clk);
      #1;
   endtask
   task automatic conv(input logic [DATA_W-1:0] ctrl, output int n, output int s);
      n = 0;
      s = -1;
      wr(ADDR_CTRL, ctrl);
      // Look just after each edge so the count starts on the first busy cycle
      for (int w = 0; w < 300 && conv_active !== 1'b1; w++) begin
         @(posedge ref_clk);
         #1;
      end
      while (conv_active === 1'b1 && n < 400) begin
         if (sample_hold === 1'b1) s = n;
         @(posedge ref_clk);
         #1 n++;
      end
   endtask
   task automatic t_first();
      @(posedge ref_clk);
      result_in <= 10'h2a5;
      wr(ADDR_IRQ_EN, 16'h0001);
      conv(16'h0003, len, sh);
      chk(16'(len), 16'd50);
      chk(16'(sh), 16'd27);
      rd(ADDR_CTRL);
      chk(rv, 16'h0001);
      rd(ADDR_DATA);
      chk(rv, 16'h02a5);
      rd(ADDR_STATUS);
      chk(rv, 16'h0001);
      chk({15'h0, irq}, 16'h0001);
      wr(ADDR_CLEAR, 16'h0001);
      @(posedge ref_clk);
      #1;
      chk({15'h0, irq}, 16'h0000);
      @(posedge ref_clk);
      result_in <= 10'h15a;
      conv(16'h0003, len2, sh2);
      chk(16'(len2), 16'd26);
      chk(16'(sh2), 16'd3);
      chk(16'(sh - sh2), 16'd24);
      rd(ADDR_DATA);
      chk(rv, 16'h015a);
   endtask
   task automatic t_abort();
      wr(ADDR_IRQ_EN, 16'h0000);
      wr(ADDR_CLEAR, 16'h0003);
      wr(ADDR_CTRL, 16'h0003);
      repeat (10) @(posedge ref_clk);
      rd(ADDR_CTRL);
      chk(rv, 16'h0003);
      wr(ADDR_CTRL, 16'h0000);
      rd(ADDR_CTRL);
      chk(rv, 16'h0000);
      conv(16'h0003, len, sh);
      chk(16'(len), 16'd50);
      conv(16'h0013, len, sh);
      chk(16'(len), 16'd52);
      chk(16'(sh), 16'd6);
      rd(ADDR_STATUS);
      chk(rv, 16'h0001);
      chk({15'h0, irq}, 16'h0000);
      wr(ADDR_IRQ_EN, 16'h0001);
      @(posedge ref_clk);
      #1;
      chk({15'h0, irq}, 16'h0001);
      wr(ADDR_CLEAR, 16'h0001);
   endtask
   task automatic t_free();
      len = 0;
      wr(ADDR_CTRL, 16'h000b);
      repeat (130) begin
         @(posedge ref_clk);
         #1;
         if (sample_hold === 1'b1) begin
            len++;
         end
      end
      chk(16'(len), 16'd5);
      rd(ADDR_CTRL);
      chk(rv, 16'h000b);
      wr(ADDR_CTRL, 16'h0001);
      wait_idle();
      rd(ADDR_CTRL);
      chk(rv, 16'h0001);
   endtask
   // Trigger after a phase offset; optionally a second edge while busy
   task automatic trig(input int pre, input logic miss, output int n);
      n = 0;
      repeat (pre) @(posedge ref_clk);
      trigger_in <= 1'b1;
      while (sample_hold !== 1'b1 && n < 60) begin
         @(posedge ref_clk);
         #1 n++;
      end
      @(posedge ref_clk);
      trigger_in <= 1'b0;
      repeat (4) @(posedge ref_clk);
      trigger_in <= miss;
      repeat (4) @(posedge ref_clk);
      trigger_in <= 1'b0;
      wait_idle();
   endtask
   task automatic t_auto();
      wr(ADDR_CLEAR, 16'h0003);
      wr(ADDR_CTRL, 16'h0005);
      trig(3, 1'b0, len);
      trig(4, 1'b1, len2);
      chk(16'(len), 16'(len2));
      // Three sync cycles, two converter cycles of two, one output flop
      chk(16'(len), 16'd8);
      rd(ADDR_STATUS);
      chk(rv, 16'h0003);
   endtask
   // Reset in mid conversion clears outputs and registers
   task automatic t_reset();
      wr(ADDR_CTRL, 16'h0003);
      repeat (10) @(posedge ref_clk);
      resetn <= 1'b0;
      @(posedge ref_clk);
      #1;
      chk({12'h0, conv_active, irq, sample_hold, |reg_rdata}, 16'h0000);
      repeat (4) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rd(ADDR_CTRL);
      chk(rv, 16'h0000);
      rd(ADDR_STATUS);
      chk(rv, 16'h0000);
   endtask
   initial begin
      resetn = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      trigger_in = 1'b0;
      result_in = '0;
      fails = 0;
      comparisons = 0;
      repeat (5) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rd(ADDR_CTRL);
      chk(rv, 16'h0000);
      rd(3'h7);
      chk(rv, 16'h0000);
      t_first();
      t_abort();
      t_free();
      t_auto();
      t_reset();
      summarize();
   end
endmodule // acs_sequencer_bench
bind acs_sequencer acs_sequencer_checker i_acs_sequencer_checker (.ref_clk(ref_clk),
   .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_hold(sample_hold),
   .conv_active(conv_active), .irq(irq));
`default_nettype wire
